//--- verilog/redriver_pkg.sv
// Purpose: shared constants for the redriver strap and status logic
// Assumes: 200 MHz CLOCK, synchronous active-high RST
// Notes: sensitivity codes follow the three-level strap reading
package redriver_pkg;
	localparam logic [1:0] SENS_LOW = 2'h0;
	localparam logic [1:0] SENS_MEDIUM = 2'h1;
	localparam logic [1:0] SENS_HIGH = 2'h2;
	localparam logic [1:0] SENS_RESET = SENS_MEDIUM;
	localparam logic [1:0] BOOST_RESET = 2'h0;
	localparam int BOOST_W = 2;
	localparam int SYNC_STAGES = 2;
	typedef enum logic [1:0]
	{
		ST_OFF = 2'h0,
		ST_RUN = 2'h1
	} run_state_t;
endpackage

//--- verilog/redriver_strap_and_status_logic.sv
// Purpose: mode, strap latching and status flags of a USB 2.0 redriver
// Assumes: pin levels and analog detector outputs arrive asynchronously
// Notes: three-level strap arrives as separate high and low comparator bits
// Functional notes
// (R1) Both serial pins pulled up at power-up select serial mode, else pin mode.
// (R2) Weak pull-down on shared clock/attach pin while enable is rising.
// (R3) Board leaves serial data pin unconnected in pin mode.
// (R4) Pin mode drives attach flag: set on D+/D- pull-up, clear on disconnect.
// (R5) Enable low holds the device in reset and shutdown.
// (R6) Enable driver holds it low until supply is within range.
// (R7) Boost sampled only at enable release; later changes ignored.
// (R8) Sensitivity strap read as three levels during reset in pin mode.
// (R9) After reset in pin mode the strap pin outputs the high-speed flag.
// (R10) High-speed flag set on test fixture then test packet from unconnected.
// (R11) High-speed flag set on successful high-speed handshake.
// (R12) In serial mode the strap pin is neither sampled nor driven.
// (R13) Mode, boost and sensitivity latched together, held until next reset.
module redriver_strap_and_status_logic
	import redriver_pkg::*;
(
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RST,
	// Enable pin and configuration straps
	input wire logic ACTIVE_LOW_ENABLE,
	input wire logic SERIAL_DATA_IN,
	input wire logic CLOCK_OR_ATTACH_PIN_IN,
	input wire logic [redriver_pkg::BOOST_W-1:0] BOOST_STRAP,
	input wire logic SENSE_STRAP_HIGH,
	input wire logic SENSE_STRAP_LOW,
	// Channel detector events
	input wire logic PULLUP_SEEN,
	input wire logic DISCONNECT_SEEN,
	input wire logic TEST_FIXTURE_SEEN,
	input wire logic TEST_PACKET_SEEN,
	input wire logic SPEED_HANDSHAKE_DONE,
	// Latched configuration and state
	output logic SERIAL_MODE,
	output logic [redriver_pkg::BOOST_W-1:0] BOOST_LEVEL,
	output logic [1:0] SENSITIVITY,
	output logic SHUTDOWN,
	// Shared pins
	output logic CLOCK_OR_ATTACH_PIN_OUT,
	output logic CLOCK_OR_ATTACH_PIN_OE,
	output logic CLOCK_OR_ATTACH_PULLDOWN,
	output logic SENSITIVITY_OR_SPEED_PIN_OUT,
	output logic SENSITIVITY_OR_SPEED_PIN_OE
);
	import redriver_pkg::*;

	localparam int NIN = 10;
	logic [NIN-1:0] raw;
	logic [NIN-1:0] s1;
	logic [NIN-1:0] s2;
	assign raw = {ACTIVE_LOW_ENABLE, SERIAL_DATA_IN, CLOCK_OR_ATTACH_PIN_IN,
		SENSE_STRAP_HIGH, SENSE_STRAP_LOW, PULLUP_SEEN, DISCONNECT_SEEN,
		TEST_FIXTURE_SEEN, TEST_PACKET_SEEN, SPEED_HANDSHAKE_DONE};

	// Every asynchronous input passes two flops before use
	genvar gi;
	generate
		for (gi = 0; gi < NIN; gi++)
		begin : g_sync
			always_ff @(posedge CLOCK)
			begin
				if (RST)
				begin
					s1[gi] <= 1'b0;
					s2[gi] <= 1'b0;
				end
				else
				begin
					s1[gi] <= raw[gi];
					s2[gi] <= s1[gi];
				end
			end
		end
	endgenerate

	logic [BOOST_W-1:0] boost_s1;
	logic [BOOST_W-1:0] boost_s2;
	always_ff @(posedge CLOCK)
	begin
		if (RST)
		begin
			boost_s1 <= BOOST_RESET;
			boost_s2 <= BOOST_RESET;
		end
		else
		begin
			boost_s1 <= BOOST_STRAP;
			boost_s2 <= boost_s1;
		end
	end

	logic en_n;
	logic sda_s;
	logic scl_s;
	logic sh_s;
	logic sl_s;
	logic pu_s;
	logic dis_s;
	logic fix_s;
	logic pkt_s;
	logic hsk_s;
	assign {en_n, sda_s, scl_s, sh_s, sl_s, pu_s, dis_s, fix_s, pkt_s,
		hsk_s} = s2;

	run_state_t state;
	run_state_t next_state;
	logic serial_mode;
	logic next_serial_mode;
	logic [BOOST_W-1:0] boost;
	logic [BOOST_W-1:0] next_boost;
	logic [1:0] sens;
	logic [1:0] next_sens;
	logic attached;
	logic next_attached;
	logic fixture;
	logic next_fixture;
	logic speed_flag;
	logic next_speed_flag;
	logic release_now;
	logic running;

	assign release_now = (state == ST_OFF) && en_n;
	assign running = (state == ST_RUN) && en_n;

	always_comb
	begin
		next_state = state;
		next_serial_mode = serial_mode;
		next_boost = boost;
		next_sens = sens;
		next_attached = attached;
		next_fixture = fixture;
		next_speed_flag = speed_flag;
		case (state)
			ST_OFF:
			begin
				next_attached = 1'b0;
				next_fixture = 1'b0;
				next_speed_flag = 1'b0;
				if (en_n)
				begin
					// All three straps taken in the same cycle
					next_state = ST_RUN; // R13
					next_serial_mode = sda_s && scl_s; // R1
					next_boost = boost_s2; // R7
					if (!(sda_s && scl_s)) // R12
					begin
						// Conflicting comparators read as floating
						if (sh_s && !sl_s)
							next_sens = SENS_HIGH; // R8
						else if (sl_s && !sh_s)
							next_sens = SENS_LOW; // R8
						else
							next_sens = SENS_MEDIUM; // R8
					end
					else
						next_sens = SENS_RESET;
				end
			end
			ST_RUN:
			begin
				if (!en_n)
					next_state = ST_OFF; // R5
				else if (!serial_mode)
				begin
					// Disconnect outranks a simultaneous attach
					if (dis_s)
						next_attached = 1'b0; // R4
					else if (!attached && pu_s)
						next_attached = 1'b1; // R4
					if (dis_s)
						next_fixture = 1'b0;
					else if (!attached && fix_s)
						next_fixture = 1'b1; // R10
					if (dis_s)
						next_speed_flag = 1'b0;
					else if ((fixture && pkt_s) || hsk_s)
						next_speed_flag = 1'b1; // R10 R11
				end
			end
			default:
				next_state = ST_OFF;
		endcase
	end

	always_ff @(posedge CLOCK)
	begin
		if (RST)
		begin
			state <= ST_OFF;
			serial_mode <= 1'b0;
			boost <= BOOST_RESET;
			sens <= SENS_RESET;
			attached <= 1'b0;
			fixture <= 1'b0;
			speed_flag <= 1'b0;
		end
		else
		begin
			state <= next_state;
			serial_mode <= next_serial_mode;
			boost <= next_boost;
			sens <= next_sens;
			attached <= next_attached;
			fixture <= next_fixture;
			speed_flag <= next_speed_flag;
		end
	end

	// Registered pin drive; one cycle behind the state it shows
	always_ff @(posedge CLOCK)
	begin
		if (RST)
		begin
			SHUTDOWN <= 1'b1;
			CLOCK_OR_ATTACH_PULLDOWN <= 1'b1;
			CLOCK_OR_ATTACH_PIN_OUT <= 1'b0;
			CLOCK_OR_ATTACH_PIN_OE <= 1'b0;
			SENSITIVITY_OR_SPEED_PIN_OUT <= 1'b0;
			SENSITIVITY_OR_SPEED_PIN_OE <= 1'b0;
			SERIAL_MODE <= 1'b0;
			BOOST_LEVEL <= BOOST_RESET;
			SENSITIVITY <= SENS_RESET;
		end
		else
		begin
			SHUTDOWN <= (state != ST_RUN); // R5
			CLOCK_OR_ATTACH_PULLDOWN <= (state == ST_OFF); // R2
			CLOCK_OR_ATTACH_PIN_OUT <= attached; // R4
			CLOCK_OR_ATTACH_PIN_OE <= running && !serial_mode; // R4
			SENSITIVITY_OR_SPEED_PIN_OUT <= speed_flag; // R9
			SENSITIVITY_OR_SPEED_PIN_OE <= running && !serial_mode; // R9 R12
			SERIAL_MODE <= serial_mode;
			BOOST_LEVEL <= boost;
			SENSITIVITY <= sens;
		end
	end

	a_boost_hold: assert property (@(posedge CLOCK) disable iff (RST) // R7
		(state == ST_RUN && $past(state) == ST_RUN) |-> $stable(boost))
		else $error("boost changed while running");
	a_serial_quiet: assert property (@(posedge CLOCK) disable iff (RST) // R12
		SERIAL_MODE |-> !SENSITIVITY_OR_SPEED_PIN_OE)
		else $error("strap pin driven in serial mode");
	a_off_shutdown: assert property (@(posedge CLOCK) disable iff (RST) // R5
		(state == ST_OFF) |=> SHUTDOWN && !CLOCK_OR_ATTACH_PIN_OE)
		else $error("not shut down while enable low");
	a_pulldown_off: assert property (@(posedge CLOCK) disable iff (RST) // R2
		(state == ST_RUN) |=> !CLOCK_OR_ATTACH_PULLDOWN)
		else $error("pull-down left on while running");
	a_mode_latch: assert property (@(posedge CLOCK) disable iff (RST) // R1
		release_now |=> serial_mode == $past(sda_s && scl_s))
		else $error("mode not latched at release");
	sequence s_attach_cause;
		running && !serial_mode && !attached && pu_s && !dis_s;
	endsequence
	a_attach_set: assert property (@(posedge CLOCK) disable iff (RST) // R4
		s_attach_cause ##1 en_n |=> CLOCK_OR_ATTACH_PIN_OUT)
		else $error("attach flag missed");
	a_detach: assert property (@(posedge CLOCK) disable iff (RST) // R4
		(running && !serial_mode && dis_s) |=> !attached)
		else $error("attach flag kept after disconnect");
	sequence s_handshake;
		running && !serial_mode && hsk_s && !dis_s;
	endsequence
	a_speed_hsk: assert property (@(posedge CLOCK) disable iff (RST) // R11
		s_handshake |=> speed_flag)
		else $error("handshake did not set speed flag");
	a_speed_packet: assert property (@(posedge CLOCK) disable iff (RST) // R10
		(running && !serial_mode && fixture && pkt_s && !dis_s)
		|=> speed_flag)
		else $error("test packet did not set speed flag");
	a_sens_three: assert property (@(posedge CLOCK) disable iff (RST) // R8
		(release_now && !(sda_s && scl_s) && sh_s && !sl_s)
		|=> sens == SENS_HIGH)
		else $error("high sensitivity not latched");
	a_latch_together: assert property (@(posedge CLOCK) disable iff (RST) // R13
		(state == ST_RUN && $past(state) == ST_RUN)
		|-> $stable(sens) && $stable(serial_mode))
		else $error("configuration moved while running");
endmodule // redriver_strap_and_status_logic

//--- tb/usb_far_side_model.sv
// Purpose: far-side USB port seen through the channel detectors
// Assumes: one event at a time, requested by the bench
// Notes: each event lasts two cycles, above the one-cycle minimum
module usb_far_side_model
(
	// Clock
	input wire logic clock,
	// Event request
	input wire logic [2:0] event_code,
	input wire logic fire,
	// Detector levels: pull-up, disconnect, fixture, packet, handshake
	output logic [4:0] seen
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] hold = 2'h0;
	logic [2:0] code = 3'h0;
	always @(posedge clock)
	begin
		if (fire)
		begin
			hold <= 2'h2;
			code <= event_code;
		end
		else if (hold != 2'h0)
			hold <= hold - 2'h1;
	end
	// Bench orders fixture before packet when it wants a speed report
	assign seen = (hold != 2'h0) ? (5'h01 << code) : 5'h00;
endmodule // usb_far_side_model

//--- tb/redriver_strap_and_status_logic_tb.sv
// Purpose: self-checking bench for the strap and status logic
// Assumes: 200 MHz clock, straps settle before enable rises
// Notes: serial data pin held low in pin mode, as if left open, except the last strap row, which drives it high with the clock pin low
module redriver_strap_and_status_logic_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import redriver_pkg::*;
	logic CLOCK, RST, en, sd, cl, sh, sl, fire;
	logic [1:0] boost, blev, sens;
	logic [2:0] code;
	logic [4:0] seen;
	logic smode, shut, a_out, a_oe, pd, h_out, h_oe;
	logic [10:0] rows [6];
	int mismatches, n_tests;
	redriver_strap_and_status_logic u_redriver_strap_and_status_logic (
		.CLOCK(CLOCK), .RST(RST), .ACTIVE_LOW_ENABLE(en),
		.SERIAL_DATA_IN(sd), .CLOCK_OR_ATTACH_PIN_IN(cl),
		.BOOST_STRAP(boost), .SENSE_STRAP_HIGH(sh), .SENSE_STRAP_LOW(sl),
		.PULLUP_SEEN(seen[0]), .DISCONNECT_SEEN(seen[1]),
		.TEST_FIXTURE_SEEN(seen[2]), .TEST_PACKET_SEEN(seen[3]),
		.SPEED_HANDSHAKE_DONE(seen[4]), .SERIAL_MODE(smode),
		.BOOST_LEVEL(blev), .SENSITIVITY(sens), .SHUTDOWN(shut),
		.CLOCK_OR_ATTACH_PIN_OUT(a_out), .CLOCK_OR_ATTACH_PIN_OE(a_oe),
		.CLOCK_OR_ATTACH_PULLDOWN(pd), .SENSITIVITY_OR_SPEED_PIN_OUT(h_out),
		.SENSITIVITY_OR_SPEED_PIN_OE(h_oe));
	usb_far_side_model u_usb_far_side_model (.clock(CLOCK),
		.event_code(code), .fire(fire), .seen(seen));
	initial
	begin
		CLOCK = 1'b0;
		forever #2.5 CLOCK = ~CLOCK;
	end
	task automatic step(input int n);
		repeat (n) @(posedge CLOCK);
	endtask
	// Sampled mid-cycle so the edge's register updates have landed
	task automatic chk(input logic [4:0] got, input logic [4:0] exp);
		@(negedge CLOCK);
		n_tests++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
		@(posedge CLOCK);
	endtask
	task automatic ev(input logic [2:0] c);
		code <= c;
		fire <= 1'b1;
		step(1);
		fire <= 1'b0;
		step(8);
	endtask
	task automatic complete_run;
		if (mismatches == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		#20000;
		mismatches++;
		complete_run;
	end
	initial
	begin
		RST = 1'b1;
		{en, sd, cl, boost, sh, sl, fire, code} = 11'h000;
		// {data, clock, boost, high, low} then {mode, boost, sensitivity}
		rows = '{11'h042, 11'h085, 11'h128, 11'h1ED, 11'h759, 11'h4A4};
		step(16);
		chk({shut, pd, a_oe, h_oe}, 5'h0C);
		RST <= 1'b0;
		foreach (rows[i])
		begin
			{sd, cl, boost, sh, sl} <= rows[i][10:5];
			step(4);
			en <= 1'b1;
			step(6);
			chk({smode, blev, sens}, rows[i][4:0]);
			chk({shut, pd, a_oe, h_oe}, {2'h0, {2{~rows[i][4]}}});
			// Straps moved while running must not reach the outputs
			{boost, sh, sl} <= ~rows[i][8:5];
			step(6);
			chk({smode, blev, sens}, rows[i][4:0]);
			en <= 1'b0;
			step(6);
			chk({shut, pd}, 5'h03);
		end
		{sd, cl} <= 2'h0;
		step(4);
		en <= 1'b1;
		step(6);
		ev(3'h3);
		chk(h_out, 5'h00);
		ev(3'h0);
		chk({a_oe, a_out, h_out}, 5'h06);
		// Fixture seen while attached must not arm the speed report
		ev(3'h2);
		ev(3'h3);
		chk(h_out, 5'h00);
		ev(3'h1);
		chk({a_out, h_out}, 5'h00);
		ev(3'h2);
		ev(3'h3);
		chk(h_out, 5'h01);
		ev(3'h1);
		ev(3'h4);
		chk({h_oe, h_out}, 5'h03);
		en <= 1'b0;
		step(6);
		chk({shut, a_oe, h_oe}, 5'h04);
		{sd, cl} <= 2'h3;
		step(4);
		en <= 1'b1;
		step(6);
		ev(3'h0);
		ev(3'h4);
		chk({smode, h_oe, sens}, {2'h2, SENS_MEDIUM});
		chk({a_oe, a_out, h_out}, 5'h00);
		// Reset in mid-run, then a fresh release takes the straps again
		RST <= 1'b1;
		step(2);
		chk({shut, pd, smode, a_oe, h_oe}, 5'h18);
		RST <= 1'b0;
		step(10);
		chk({smode, blev, sens}, {1'b1, 2'h2, SENS_MEDIUM});
		complete_run;
	end
endmodule // redriver_strap_and_status_logic_tb
